// ===== iea_core_model.sv
// memory stand-in on the far side of the interrupt entry arbiter
// assumes byte writes and reads with one cycle of read latency
`timescale 1ns/1ps

module iea_core_model (
  // clock
  input  wire logic        i_sys_clk,
  // memory bus from the arbiter
  input  wire logic [15:0] i_bus_addr,
  input  wire logic [7:0]  i_bus_wdata,
  input  wire logic        i_bus_wr,
  input  wire logic        i_bus_rd,
  // read data back
  output logic [7:0]       o_rd_data
);
  logic [7:0] mem [0:65535];
  int         wr_count = 0;

  // start from a known byte so the idle toggle is visible
  initial begin
    o_rd_data = 8'h00;
  end

  // byte store and one cycle read; idle data toggles so a stale byte never passes
  always @(posedge i_sys_clk) begin
    if (i_bus_wr) begin
      mem[i_bus_addr] <= i_bus_wdata;
      wr_count <= wr_count + 1;
    end
    if (i_bus_rd) begin
      o_rd_data <= mem[i_bus_addr];
    end else begin
      o_rd_data <= ~o_rd_data;
    end
  end
endmodule

// ===== iea_interrupt_entry_arbiter.sv
// interrupt entry and return sequencer with request arbitration
// assumes the core stalls while o_busy is high, read data arrive one cycle after o_bus_rd,
// and i_trap_go, i_rfi_go and i_insn_done are one-cycle pulses at instruction boundaries
// Function
// RULE1 - on entry, push working registers to the stack before fetching the vector
// RULE2 - entry sets the global interrupt mask flag
// RULE3 - return instruction pulls the saved registers back from the stack
// RULE4 - module requests are latched; arbitration happens when processing starts
// RULE5 - arbitration yields a fixed code that selects the vector pair
// RULE6 - a latched winner is not displaced until serviced or mask cleared
// RULE7 - hardware requests are acted on only while the mask flag is clear
// RULE8 - the software trap always starts processing, ignoring the mask flag
// RULE9 - requests are examined only at instruction completion, never mid-instruction
// RULE10 - with several pending, the highest priority request is serviced first
// RULE11 - the high index byte is never pushed on entry
// RULE12 - push pcl, pch, x, a, flags descending, then read vector high, low
`timescale 1ns/1ps
`include "iea_regs.svh"

module iea_interrupt_entry_arbiter #(
  parameter int NUM_SRC = `IEA_NUM_SRC,
  parameter int CODE_W  = `IEA_CODE_W
) (
  // clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst_b,
  // peripheral requests, already gated by their own enables
  input  wire logic [NUM_SRC-1:0]  i_irq_req,
  // core instruction events
  input  wire logic                i_insn_done,
  input  wire logic                i_trap_go,
  input  wire logic                i_rfi_go,
  input  wire logic                i_mask_set,
  input  wire logic                i_mask_clr,
  // core register values
  input  wire logic [15:0]         i_ret_pc,
  input  wire logic [15:0]         i_sp,
  input  wire logic [7:0]          i_acc,
  input  wire logic [7:0]          i_idx_lo,
  input  wire logic [7:0]          i_cfr,
  // memory bus
  input  wire logic [7:0]          i_rd_data,
  output logic [15:0]              o_bus_addr,
  output logic [7:0]               o_bus_wdata,
  output logic                     o_bus_wr,
  output logic                     o_bus_rd,
  // results to the core
  output logic                     o_busy,
  output logic                     o_mask_flag,
  output logic [CODE_W-1:0]        o_vec_code,
  output logic                     o_entry_done,
  output logic                     o_return_done,
  output logic [15:0]              o_new_pc,
  output logic [15:0]              o_new_sp,
  output logic [7:0]               o_acc,
  output logic [7:0]               o_idx_lo,
  output logic [7:0]               o_cfr
);

  iea_pkg::iea_state_type state_reg, state_next;
  logic [15:0]       addr_reg, addr_next, sp_reg, sp_next, pc_reg, pc_next;
  logic [7:0]        wdata_reg, wdata_next, acc_reg, acc_next;
  logic [7:0]        idx_reg, idx_next, cfr_reg, cfr_next;
  logic              wr_reg, wr_next, rd_reg, rd_next, busy_reg, busy_next;
  logic              mask_reg, mask_next, trap_reg, trap_next;
  logic              edone_reg, edone_next, rdone_reg, rdone_next;
  logic [CODE_W-1:0] code_reg, code_next, sel_code;
  logic              arb_start, arb_done, arb_pend, arb_valid;
  logic [CODE_W-1:0] arb_code;
  logic [15:0]       vec_addr;

  // request latches and arbitration
  iea_req_arbiter #(
    .NUM_SRC (NUM_SRC),
    .CODE_W  (CODE_W)
  ) u_arb (
    .i_sys_clk   (i_sys_clk),
    .i_rst_b     (i_rst_b),
    .i_req       (i_irq_req),
    .i_start     (arb_start),
    .i_done      (arb_done),
    .i_unlock    (i_mask_clr),
    .o_any_pend  (arb_pend),
    .o_win_valid (arb_valid),
    .o_win_code  (arb_code)
  );

  // vector pair address from the selected code
  assign sel_code = trap_reg ? `IEA_TRAP_CODE : arb_code;   // see RULE5
  assign vec_addr = `IEA_VEC_TOP - {{(15 - CODE_W){1'b0}}, sel_code, 1'b0};

  // sequencer next values
  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    wdata_next = `IEA_BYTE_RST;
    wr_next    = 1'b0;
    rd_next    = 1'b0;
    busy_next  = busy_reg;
    mask_next  = mask_reg;
    trap_next  = trap_reg;
    code_next  = code_reg;
    sp_next    = sp_reg;
    pc_next    = pc_reg;
    acc_next   = acc_reg;
    idx_next   = idx_reg;
    cfr_next   = cfr_reg;
    edone_next = 1'b0;
    rdone_next = 1'b0;
    arb_start  = 1'b0;
    arb_done   = 1'b0;
    if (i_mask_set) begin
      mask_next = 1'b1;
    end
    if (i_mask_clr) begin
      mask_next = 1'b0;
    end
    case (state_reg)
      iea_pkg::IEA_IDLE: begin
        if (i_trap_go || (i_insn_done && !i_rfi_go && !mask_reg && arb_pend)) begin   // see RULE7 RULE8 RULE9
          arb_start  = !i_trap_go;   // see RULE4
          trap_next  = i_trap_go;
          state_next = iea_pkg::IEA_PUSH_PCL;
          busy_next  = 1'b1;
          sp_next    = i_sp;
          pc_next    = i_ret_pc;
          acc_next   = i_acc;
          idx_next   = i_idx_lo;
          cfr_next   = i_cfr;
          cfr_next[`IEA_CFR_MASK_BIT] = mask_reg;
          addr_next  = i_sp;
          wdata_next = i_ret_pc[7:0];   // see RULE12
          wr_next    = 1'b1;
        end else if (i_rfi_go) begin
          state_next = iea_pkg::IEA_POP_CFR;
          busy_next  = 1'b1;
          sp_next    = i_sp;
          addr_next  = i_sp + 16'h0001;   // see RULE3
          rd_next    = 1'b1;
        end
      end
      iea_pkg::IEA_PUSH_PCL: begin
        state_next = iea_pkg::IEA_PUSH_PCH;
        addr_next  = sp_reg - 16'h0001;
        wdata_next = pc_reg[15:8];   // see RULE1
        wr_next    = 1'b1;
      end
      iea_pkg::IEA_PUSH_PCH: begin
        state_next = iea_pkg::IEA_PUSH_X;
        addr_next  = sp_reg - 16'h0002;
        wdata_next = idx_reg;   // low index byte only, see RULE11
        wr_next    = 1'b1;
      end
      iea_pkg::IEA_PUSH_X: begin
        state_next = iea_pkg::IEA_PUSH_A;
        addr_next  = sp_reg - 16'h0003;
        wdata_next = acc_reg;
        wr_next    = 1'b1;
      end
      iea_pkg::IEA_PUSH_A: begin
        state_next = iea_pkg::IEA_PUSH_CFR;
        addr_next  = sp_reg - 16'h0004;
        wdata_next = cfr_reg;   // see RULE12
        wr_next    = 1'b1;
      end
      iea_pkg::IEA_PUSH_CFR: begin
        state_next = iea_pkg::IEA_VEC_HI;
        mask_next  = 1'b1;   // see RULE2
        code_next  = sel_code;
        addr_next  = vec_addr;   // vector read only after the pushes, see RULE1
        rd_next    = 1'b1;
      end
      iea_pkg::IEA_VEC_HI: begin
        state_next = iea_pkg::IEA_VEC_LO;
        mask_next  = 1'b1;
        addr_next  = addr_reg + 16'h0001;
        rd_next    = 1'b1;
      end
      iea_pkg::IEA_VEC_LO: begin
        state_next = iea_pkg::IEA_VEC_DONE;
        mask_next  = 1'b1;
        pc_next    = {i_rd_data, pc_reg[7:0]};
      end
      iea_pkg::IEA_VEC_DONE: begin
        state_next = iea_pkg::IEA_IDLE;
        mask_next  = 1'b1;
        arb_done   = !trap_reg;   // see RULE6
        pc_next    = {pc_reg[15:8], i_rd_data};
        sp_next    = sp_reg - `IEA_FRAME_BYTES;
        busy_next  = 1'b0;
        edone_next = 1'b1;
      end
      iea_pkg::IEA_POP_CFR: begin
        state_next = iea_pkg::IEA_POP_A;
        addr_next  = sp_reg + 16'h0002;
        rd_next    = 1'b1;
      end
      iea_pkg::IEA_POP_A: begin
        state_next = iea_pkg::IEA_POP_X;
        cfr_next   = i_rd_data;
        addr_next  = sp_reg + 16'h0003;
        rd_next    = 1'b1;
      end
      iea_pkg::IEA_POP_X: begin
        state_next = iea_pkg::IEA_POP_PCH;
        acc_next   = i_rd_data;
        addr_next  = sp_reg + 16'h0004;
        rd_next    = 1'b1;
      end
      iea_pkg::IEA_POP_PCH: begin
        state_next = iea_pkg::IEA_POP_PCL;
        idx_next   = i_rd_data;
        addr_next  = sp_reg + 16'h0005;
        rd_next    = 1'b1;
      end
      iea_pkg::IEA_POP_PCL: begin
        state_next = iea_pkg::IEA_POP_DONE;
        pc_next    = {i_rd_data, pc_reg[7:0]};
      end
      iea_pkg::IEA_POP_DONE: begin
        state_next = iea_pkg::IEA_IDLE;
        pc_next    = {pc_reg[15:8], i_rd_data};
        sp_next    = sp_reg + `IEA_FRAME_BYTES;
        mask_next  = cfr_reg[`IEA_CFR_MASK_BIT];   // see RULE3
        busy_next  = 1'b0;
        rdone_next = 1'b1;
      end
      default: begin
        state_next = iea_pkg::IEA_IDLE;
        busy_next  = 1'b0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state_reg <= iea_pkg::IEA_IDLE;
      addr_reg  <= `IEA_ADDR_RST;
      wdata_reg <= `IEA_BYTE_RST;
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      busy_reg  <= 1'b0;
      mask_reg  <= `IEA_MASK_RST;
      trap_reg  <= 1'b0;
      code_reg  <= `IEA_TRAP_CODE;
      sp_reg    <= `IEA_ADDR_RST;
      pc_reg    <= `IEA_ADDR_RST;
      acc_reg   <= `IEA_BYTE_RST;
      idx_reg   <= `IEA_BYTE_RST;
      cfr_reg   <= `IEA_BYTE_RST;
      edone_reg <= 1'b0;
      rdone_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      wr_reg    <= wr_next;
      rd_reg    <= rd_next;
      busy_reg  <= busy_next;
      mask_reg  <= mask_next;
      trap_reg  <= trap_next;
      code_reg  <= code_next;
      sp_reg    <= sp_next;
      pc_reg    <= pc_next;
      acc_reg   <= acc_next;
      idx_reg   <= idx_next;
      cfr_reg   <= cfr_next;
      edone_reg <= edone_next;
      rdone_reg <= rdone_next;
    end
  end

  // outputs straight from flip-flops
  assign o_bus_addr    = addr_reg;
  assign o_bus_wdata   = wdata_reg;
  assign o_bus_wr      = wr_reg;
  assign o_bus_rd      = rd_reg;
  assign o_busy        = busy_reg;
  assign o_mask_flag   = mask_reg;
  assign o_vec_code    = code_reg;
  assign o_entry_done  = edone_reg;
  assign o_return_done = rdone_reg;
  assign o_new_pc      = pc_reg;
  assign o_new_sp      = sp_reg;
  assign o_acc         = acc_reg;
  assign o_idx_lo      = idx_reg;
  assign o_cfr         = cfr_reg;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_push_frame;
    (o_bus_wr && !o_bus_rd)[*5];
  endsequence
  sequence s_vec_read;
    (o_bus_rd && !o_bus_wr)[*2] ##1 !o_bus_rd ##1 o_entry_done;
  endsequence
  sequence s_pop_frame;
    (o_bus_rd && !o_bus_wr)[*5] ##1 !o_bus_rd ##1 o_return_done;
  endsequence

  a_push_then_vector: assert property ($rose(o_bus_wr) && state_reg == iea_pkg::IEA_PUSH_PCL
                                       |-> s_push_frame ##1 s_vec_read)   // see RULE1
    else $error("entry order wrong");
  a_entry_masks: assert property (o_entry_done |-> o_mask_flag && $past(o_mask_flag, 3))   // see RULE2
    else $error("mask not set on entry");
  a_return_pops: assert property (state_reg == iea_pkg::IEA_POP_CFR && o_bus_addr == o_new_sp + 16'h0001
                                  |-> s_pop_frame)   // see RULE3
    else $error("return sequence wrong");
  a_masked_hold: assert property (state_reg == iea_pkg::IEA_IDLE && o_mask_flag && !i_trap_go
                                  |=> state_reg != iea_pkg::IEA_PUSH_PCL)   // see RULE7
    else $error("masked request taken");
  a_trap_starts: assert property (state_reg == iea_pkg::IEA_IDLE && i_trap_go
                                  |=> state_reg == iea_pkg::IEA_PUSH_PCL && o_bus_wr)   // see RULE8
    else $error("trap did not start entry");
  a_boundary_only: assert property (state_reg == iea_pkg::IEA_IDLE && !i_trap_go && !i_insn_done
                                    |=> state_reg != iea_pkg::IEA_PUSH_PCL)   // see RULE9
    else $error("request taken mid instruction");
  a_low_index_only: assert property (state_reg == iea_pkg::IEA_PUSH_X |-> o_bus_wdata == o_idx_lo
                                     ##1 o_bus_addr == o_new_sp - 16'h0003)   // see RULE11
    else $error("wrong index byte pushed");
  a_frame_descends: assert property (state_reg == iea_pkg::IEA_PUSH_PCL
                                     |-> ##4 o_bus_addr == $past(o_bus_addr, 4) - 16'h0004)   // see RULE12
    else $error("frame addresses not descending");
  a_vector_code: assert property (state_reg == iea_pkg::IEA_VEC_HI
                                  |-> o_bus_addr == `IEA_VEC_TOP - {{(15 - CODE_W){1'b0}}, o_vec_code, 1'b0})   // see RULE5
    else $error("vector address does not match code");

endmodule

// ===== iea_pkg.sv
// types shared by the interrupt entry arbiter files
// assumes nothing of its surroundings
package iea_pkg;

  // entry and return sequencer states
  typedef enum logic [3:0] {
    IEA_IDLE     = 4'b0000,
    IEA_PUSH_PCL = 4'b0001,
    IEA_PUSH_PCH = 4'b0010,
    IEA_PUSH_X   = 4'b0011,
    IEA_PUSH_A   = 4'b0100,
    IEA_PUSH_CFR = 4'b0101,
    IEA_VEC_HI   = 4'b0110,
    IEA_VEC_LO   = 4'b0111,
    IEA_VEC_DONE = 4'b1000,
    IEA_POP_CFR  = 4'b1001,
    IEA_POP_A    = 4'b1010,
    IEA_POP_X    = 4'b1011,
    IEA_POP_PCH  = 4'b1100,
    IEA_POP_PCL  = 4'b1101,
    IEA_POP_DONE = 4'b1110
  } iea_state_type;

endpackage

// ===== iea_regs.svh
// constants for the interrupt entry arbiter
// assumes a byte-wide stack in memory that grows downward
`ifndef IEA_REGS_SVH
`define IEA_REGS_SVH

// number of peripheral request lines and width of the source code
`define IEA_NUM_SRC      8
`define IEA_CODE_W       4

// code of the software trap; hardware source i gets code i+1
`define IEA_TRAP_CODE    4'h0

// vector pair of code 0; each higher code sits two bytes lower
`define IEA_VEC_TOP      16'hfffc

// position of the mask flag inside the condition flags byte
`define IEA_CFR_MASK_BIT 3

// bytes in one stack frame (pcl, pch, x, a, flags)
`define IEA_FRAME_BYTES  16'h0005

// reset values
`define IEA_MASK_RST     1'b1
`define IEA_ADDR_RST     16'h0000
`define IEA_BYTE_RST     8'h00

`endif

// ===== iea_req_arbiter.sv
// request latches and fixed-priority arbiter with a winner lock
// assumes level requests synchronous to i_sys_clk; index 0 is highest priority
`timescale 1ns/1ps
`include "iea_regs.svh"

module iea_req_arbiter #(
  parameter int NUM_SRC = `IEA_NUM_SRC,
  parameter int CODE_W  = `IEA_CODE_W
) (
  // clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst_b,
  // peripheral requests
  input  wire logic [NUM_SRC-1:0]  i_req,
  // control from the sequencer
  input  wire logic                i_start,
  input  wire logic                i_done,
  input  wire logic                i_unlock,
  // arbitration result
  output logic                     o_any_pend,
  output logic                     o_win_valid,
  output logic [CODE_W-1:0]        o_win_code
);

  logic [NUM_SRC-1:0] pend_reg;
  logic [NUM_SRC-1:0] pend_next;
  logic [NUM_SRC-1:0] clr_vec;
  logic               lock_reg;
  logic               lock_next;
  logic [CODE_W-1:0]  code_reg;
  logic [CODE_W-1:0]  code_next;
  logic [CODE_W-1:0]  enc_code;

  // one latch per source; a new request wins over the service clear
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_latch
      assign clr_vec[gi]   = i_done && lock_reg && (code_reg == CODE_W'(gi + 1));
      assign pend_next[gi] = i_req[gi] | (pend_reg[gi] & ~clr_vec[gi]);   // see RULE4
    end
  endgenerate

  // lowest index wins among latched requests
  always_comb begin
    enc_code = `IEA_TRAP_CODE;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        enc_code = CODE_W'(i + 1);   // see RULE10
      end
    end
  end

  // lock holds the winner until serviced or the mask is cleared
  always_comb begin
    lock_next = lock_reg;
    code_next = code_reg;
    if (i_done || i_unlock) begin
      lock_next = 1'b0;   // see RULE6
    end else if (i_start && !lock_reg && (pend_reg != '0)) begin
      lock_next = 1'b1;
      code_next = enc_code;   // see RULE5
    end
  end

  // registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      pend_reg <= '0;
      lock_reg <= 1'b0;
      code_reg <= `IEA_TRAP_CODE;
    end else begin
      pend_reg <= pend_next;
      lock_reg <= lock_next;
      code_reg <= code_next;
    end
  end

  assign o_any_pend  = (pend_reg != '0);
  assign o_win_valid = lock_reg;
  assign o_win_code  = code_reg;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  a_req_latched: assert property (i_req[0] |=> pend_reg[0])   // see RULE4
    else $error("request not latched");
  a_winner_locked: assert property (lock_reg && !i_done && !i_unlock |=> $stable(code_reg) && lock_reg)   // see RULE6
    else $error("locked winner displaced");
  a_top_priority: assert property (i_start && !lock_reg && pend_reg[0] && !i_done && !i_unlock
                                   |=> code_reg == CODE_W'(1))   // see RULE10
    else $error("highest priority source not chosen");

endmodule

// ===== tb.sv
// self-checking bench for the interrupt entry arbiter
// assumes the memory stand-in answers reads one cycle after the strobe
`timescale 1ns/1ps

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); err_count++; end end

module tb;
  typedef struct { logic [7:0] req; logic [3:0] code; } iea_row_type;
  localparam logic [15:0] SP  = 16'h00f0;
  localparam logic [15:0] PC  = 16'h1234;
  localparam logic [7:0]  ACC = 8'ha5;
  localparam logic [7:0]  IDX = 8'h3c;
  localparam logic [7:0]  CFR = 8'hc1;
  iea_row_type rows [8] = '{'{8'h01, 4'h1}, '{8'h02, 4'h2}, '{8'h04, 4'h3}, '{8'h08, 4'h4},
                            '{8'h10, 4'h5}, '{8'h20, 4'h6}, '{8'h40, 4'h7}, '{8'h80, 4'h8}};
  logic [3:0] prio [3] = '{4'h1, 4'h5, 4'h7};
  int err_count = 0;
  int tests_run = 0;
  int exp_wr    = 0;
  logic i_sys_clk = 1'b0, i_rst_b = 1'b0, i_insn_done = 1'b0, i_trap_go = 1'b0;
  logic i_rfi_go = 1'b0, i_mask_set = 1'b0, i_mask_clr = 1'b0;
  logic [7:0]  i_irq_req = 8'h00;
  logic [15:0] i_sp = SP;
  logic [7:0]  i_rd_data, o_bus_wdata, o_acc, o_idx_lo, o_cfr;
  logic [15:0] o_bus_addr, o_new_pc, o_new_sp;
  logic        o_bus_wr, o_bus_rd, o_busy, o_mask_flag, o_entry_done, o_return_done;
  logic [3:0]  o_vec_code;

  // clock at 25 mhz
  initial begin
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  iea_interrupt_entry_arbiter dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_irq_req(i_irq_req),
    .i_insn_done(i_insn_done), .i_trap_go(i_trap_go), .i_rfi_go(i_rfi_go), .i_mask_set(i_mask_set),
    .i_mask_clr(i_mask_clr), .i_ret_pc(PC), .i_sp(i_sp), .i_acc(ACC), .i_idx_lo(IDX), .i_cfr(CFR),
    .i_rd_data(i_rd_data), .o_bus_addr(o_bus_addr), .o_bus_wdata(o_bus_wdata), .o_bus_wr(o_bus_wr),
    .o_bus_rd(o_bus_rd), .o_busy(o_busy), .o_mask_flag(o_mask_flag), .o_vec_code(o_vec_code),
    .o_entry_done(o_entry_done), .o_return_done(o_return_done), .o_new_pc(o_new_pc),
    .o_new_sp(o_new_sp), .o_acc(o_acc), .o_idx_lo(o_idx_lo), .o_cfr(o_cfr));

  iea_core_model p (.i_sys_clk(i_sys_clk), .i_bus_addr(o_bus_addr), .i_bus_wdata(o_bus_wdata),
    .i_bus_wr(o_bus_wr), .i_bus_rd(o_bus_rd), .o_rd_data(i_rd_data));

  // verdict and end of run
  task automatic results();
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hold reset for n cycles and look at the outputs while it is held
  task automatic do_reset(input int n);
    @(negedge i_sys_clk);
    i_rst_b = 1'b0;
    repeat (n) @(negedge i_sys_clk);
    `CHK(o_mask_flag, 1'b1)
    `CHK(o_busy, 1'b0)
    `CHK(o_vec_code, 4'h0)
    `CHK(o_bus_wr, 1'b0)
    i_rst_b = 1'b1;
  endtask

  // bounded wait for the entry or return done pulse
  task automatic wait_done(input logic ret);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge i_sys_clk);
      #1;
      if ((ret ? o_return_done : o_entry_done) === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      results();
    end
  endtask

  // request, then an instruction boundary; late raises the top source mid-entry
  task automatic hw_entry(input logic [7:0] req, input logic late);
    @(negedge i_sys_clk);
    i_irq_req = req;
    @(negedge i_sys_clk);
    i_insn_done = 1'b1;
    i_irq_req = 8'h00;
    @(negedge i_sys_clk);
    i_insn_done = 1'b0;
    if (late) begin
      @(negedge i_sys_clk);
      i_irq_req = 8'h01;
      @(negedge i_sys_clk);
      i_irq_req = 8'h00;
    end
  endtask

  // frame on the stack, vector and flags after entry
  task automatic chk_entry(input logic [3:0] code, input logic old_mask);
    wait_done(1'b0);
    exp_wr += 5;
    `CHK(o_vec_code, code)
    `CHK(o_new_pc, {8'h40 + code, 8'h20 + code})
    `CHK(o_new_sp, SP - 16'h0005)
    `CHK(o_mask_flag, 1'b1)
    `CHK(p.mem[SP], PC[7:0])
    `CHK(p.mem[SP - 16'h0001], PC[15:8])
    `CHK(p.mem[SP - 16'h0002], IDX)
    `CHK(p.mem[SP - 16'h0003], ACC)
    `CHK(p.mem[SP - 16'h0004], {CFR[7:4], old_mask, CFR[2:0]})
    `CHK(p.mem[SP - 16'h0005], 8'h5a)
    `CHK(p.wr_count, exp_wr)
  endtask

  // return from the frame just pushed
  task automatic do_rfi(input logic old_mask);
    @(negedge i_sys_clk);
    i_sp = SP - 16'h0005;
    i_rfi_go = 1'b1;
    @(negedge i_sys_clk);
    i_rfi_go = 1'b0;
    wait_done(1'b1);
    `CHK(o_acc, ACC)
    `CHK(o_idx_lo, IDX)
    `CHK(o_cfr, {CFR[7:4], old_mask, CFR[2:0]})
    `CHK(o_new_pc, PC)
    `CHK(o_new_sp, SP)
    `CHK(o_mask_flag, old_mask)
    @(negedge i_sys_clk);
    i_sp = SP;
  endtask

  // main sequence
  initial begin
    for (int c = 0; c < 9; c++) begin
      p.mem[16'hfffc - 16'(2 * c)] = 8'h40 + 8'(c);
      p.mem[16'hfffd - 16'(2 * c)] = 8'h20 + 8'(c);
    end
    p.mem[SP - 16'h0005] = 8'h5a;
    do_reset(20);
    @(negedge i_sys_clk);
    i_mask_clr = 1'b1;
    @(negedge i_sys_clk);
    i_mask_clr = 1'b0;
    // one source at a time
    for (int i = 0; i < 8; i++) begin
      hw_entry(rows[i].req, 1'b0);
      chk_entry(rows[i].code, 1'b0);
      do_rfi(1'b0);
    end
    // pending request without a boundary, then masked at a boundary
    @(negedge i_sys_clk);
    i_irq_req = 8'h02;
    repeat (4) @(negedge i_sys_clk);
    `CHK(o_busy, 1'b0)
    i_mask_set = 1'b1;
    @(negedge i_sys_clk);
    i_mask_set = 1'b0;
    i_insn_done = 1'b1;
    @(negedge i_sys_clk);
    i_insn_done = 1'b0;
    i_irq_req = 8'h00;
    repeat (3) @(negedge i_sys_clk);
    `CHK(o_busy, 1'b0)
    // trap while masked
    i_trap_go = 1'b1;
    @(negedge i_sys_clk);
    i_trap_go = 1'b0;
    chk_entry(4'h0, 1'b1);
    do_rfi(1'b1);
    // unmask, latch more sources, lock against a late top source
    @(negedge i_sys_clk);
    i_mask_clr = 1'b1;
    i_irq_req = 8'h50;
    @(negedge i_sys_clk);
    i_mask_clr = 1'b0;
    i_irq_req = 8'h00;
    hw_entry(8'h00, 1'b1);
    chk_entry(4'h2, 1'b0);
    do_rfi(1'b0);
    for (int k = 0; k < 3; k++) begin
      hw_entry(8'h00, 1'b0);
      chk_entry(prio[k], 1'b0);
      do_rfi(1'b0);
    end
    // reset in mid-run drops a latched request
    @(negedge i_sys_clk);
    i_irq_req = 8'h08;
    @(negedge i_sys_clk);
    i_irq_req = 8'h00;
    do_reset(2);
    @(posedge i_sys_clk);
    #1;
    `CHK(o_mask_flag, 1'b1)
    `CHK(o_busy, 1'b0)
    @(negedge i_sys_clk);
    i_mask_clr = 1'b1;
    @(negedge i_sys_clk);
    i_mask_clr = 1'b0;
    i_insn_done = 1'b1;
    @(negedge i_sys_clk);
    i_insn_done = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    `CHK(o_busy, 1'b0)
    `CHK(o_bus_wr, 1'b0)
    results();
  end
endmodule
